// file: testbench/sms_tb_analog.sv
// behavioural analog source and comparator facing the sequencer
`timescale 1ns/100ps

module sms_tb_analog (
    input wire logic [7:0] analog_sel,
    input wire logic [7:0] dac_code,
    input wire logic [63:0] levels,
    output logic comp_in
);
    logic [7:0] picked;

    // one-hot switch picks the level of one channel
    always_comb begin
        picked = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (analog_sel[i]) begin
                picked = levels[i*8 +: 8];
            end
        end
    end

    // comparator says keep while input is at or above the trial code
    assign comp_in = (picked >= dac_code);
endmodule // sms_tb_analog

// file: testbench/testbench.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
`include "sms_defs.svh"

module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, irq, mux_ready, conv_done, comp_in;
    logic [2:0] addr_sel = 3'h0;
    logic ale = 1'b0;
    logic conversion_trigger = 1'b0;
    logic conv_clk = 1'b0;
    logic conv_run = 1'b1;
    logic output_enable = 1'b0;
    logic [1:0] cdiv = 2'h0;
    logic [7:0] analog_sel, dac_code, data_out, data_oe;
    logic [63:0] levels = 64'h0;
    logic [31:0] seed = 32'h3821bcb6;
    logic [7:0] exp_q[$];
    logic done_q = 1'b0;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int dones = 0;
    int n, d0;

    sms_top u_sms_top (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .addr_sel(addr_sel), .ale(ale), .conversion_trigger(conversion_trigger),
        .conv_clk(conv_clk), .comp_in(comp_in), .output_enable(output_enable),
        .analog_sel(analog_sel), .mux_ready(mux_ready), .dac_code(dac_code),
        .conv_done(conv_done), .data_out(data_out), .data_oe(data_oe));

    sms_tb_analog u_sms_tb_analog (.analog_sel(analog_sel), .dac_code(dac_code),
        .levels(levels), .comp_in(comp_in));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 50) mismatches++;
    endtask

    // strobe a channel, then move the lines to show they are latched
    task strobe(input logic [2:0] ch);
        @(posedge clk_sys);
        addr_sel <= ch;
        ale <= 1'b1;
        repeat (50) @(posedge clk_sys);
        ale <= 1'b0;
        addr_sel <= ~ch;
        repeat (3) @(posedge clk_sys);
        chk(32'(analog_sel), 32'h1 << ch);
        n = 0;
        while (mux_ready !== 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(n > 560 && n < 580), 32'h1);
    endtask

    // start pulse: clears on rise, starts on fall
    task trig();
        @(posedge clk_sys);
        conversion_trigger <= 1'b1;
        repeat (50) @(posedge clk_sys);
        chk(32'(dac_code), 32'h0);
        chk(32'(conv_done), 32'h0);
        conversion_trigger <= 1'b0;
    endtask

    task wait_done();
        n = 0;
        while (conv_done !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 2000) mismatches++;
    endtask

    // clock and free conversion clock of eight system cycles
    initial forever #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cdiv <= cdiv + 2'h1;
        if (conv_run && cdiv == 2'h3) conv_clk <= ~conv_clk;
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            conclude();
        end
    end

    // watcher: compares each finished result with the oldest note
    always @(posedge clk_sys) begin
        done_q <= conv_done;
        if (conv_done === 1'b1 && done_q === 1'b0) begin
            dones++;
            if (exp_q.size() > 0) chk(32'(data_out), 32'(exp_q.pop_front()));
        end
    end

    initial begin
        for (int i = 2; i < 8; i++) begin
            seed = lfsr(seed);
            levels[i*8 +: 8] = seed[7:0];
        end
        levels[15:0] = 16'h00ff;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk(32'(data_oe), 32'h0);
        bus(1'b0, `SMS_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 5'h14, 32'hffffffff);
        bus(1'b0, 5'h14, 32'h0);
        chk(rd, 32'h0);
        $display("test registers finished");
        output_enable <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            strobe(c[2:0]);
            exp_q.push_back(levels[c*8 +: 8]);
            trig();
            wait_done();
            repeat (40) @(posedge clk_sys);
            chk(32'(conv_done), 32'h1);
        end
        chk(32'(data_oe), 32'hff);
        bus(1'b0, `SMS_OFS_RESULT, 32'h0);
        chk(rd, 32'(levels[63:56]));
        output_enable <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(32'(data_oe), 32'h0);
        $display("test channels finished");
        conv_run <= 1'b0;
        exp_q.push_back(levels[63:56]);
        trig();
        repeat (40) @(posedge clk_sys);
        chk(32'(dac_code), 32'h80);
        conv_run <= 1'b1;
        wait_done();
        seed = lfsr(seed);
        exp_q.push_back(seed[7:0]);
        trig();
        repeat (30) @(posedge clk_sys);
        levels[63:56] = seed[7:0];
        trig();
        wait_done();
        $display("test abort finished");
        bus(1'b1, `SMS_OFS_IRQ_MASK, 32'h1);
        for (int m = 1; m >= 0; m--) begin
            bus(1'b1, `SMS_OFS_IRQ_STAT, 32'h3);
            bus(1'b1, `SMS_OFS_IRQ_MASK, 32'(m));
            repeat (3) @(posedge clk_sys);
            chk(32'(irq), 32'h0);
            exp_q.push_back(levels[63:56]);
            trig();
            wait_done();
            repeat (3) @(posedge clk_sys);
            chk(32'(irq), 32'(m));
            bus(1'b0, `SMS_OFS_IRQ_STAT, 32'h0);
            chk(rd & 32'h1, 32'h1);
        end
        $display("test interrupt finished");
        exp_q.push_back(levels[63:56]);
        exp_q.push_back(levels[63:56]);
        d0 = dones;
        bus(1'b1, `SMS_OFS_CTRL, 32'h1);
        n = 0;
        while (dones < d0 + 2 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        bus(1'b1, `SMS_OFS_CTRL, 32'h0);
        repeat (200) @(posedge clk_sys);
        chk(32'(exp_q.size()), 32'h0);
        $display("test continuous finished");
        conclude();
    end
endmodule // testbench

// file: verilog/sms_defs.svh
// offsets, field positions, reset values and timing counts
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH
`define SMS_OFS_CTRL 5'h00
`define SMS_OFS_STATUS 5'h04
`define SMS_OFS_RESULT 5'h08
`define SMS_OFS_IRQ_STAT 5'h0c
`define SMS_OFS_IRQ_MASK 5'h10
`define SMS_CTRL_RETRIG 0
`define SMS_CTRL_SOFT 1
`define SMS_CTRL_RST 2'h0
`define SMS_IRQ_DONE 0
`define SMS_IRQ_MUX 1
`define SMS_IRQ_RST 2'h0
`define SMS_MSB_IDX 3'h7
`define SMS_SAR_TOP 8'h80
`define SMS_CLK_MHZ 250
`define SMS_MUX_DELAY_NS 2500
`define SMS_MUX_CYC ((`SMS_MUX_DELAY_NS * `SMS_CLK_MHZ) / 1000)
`endif

// file: verilog/sms_pkg.sv
// types shared by the sequencer
package sms_pkg;
    typedef enum logic [2:0] {
        SMS_IDLE,
        SMS_ARMED,
        SMS_RUN,
        SMS_HOLD,
        SMS_DONE
    } sms_state_e;

    typedef struct packed {
        logic [2:0] channel;
        logic mux_ready;
        logic busy;
        logic done;
    } sms_stat_s;
endpackage

// file: verilog/sms_top.sv
// control logic of the multiplexed successive-approximation converter
// Notes on behaviour
// [R1] latch select lines on strobe rising edge
// [R2] select lines binary, C high, A low
// [R3] trigger rising edge clears approximation register
// [R4] trigger falling edge starts approximation
// [R5] new trigger abandons running conversion
// [R6] done falls within 0..8 conversion clocks
// [R7] result loaded one conversion clock before done
// [R8] eight steps, one bit each, MSB first
// [R9] result is positive true
// [R10] done tied to trigger gives continuous conversion
// [R11] controller gives first trigger after power-up
// [R12] controller holds trigger high 200 ns
// [R13] controller holds strobe high 200 ns
// [R14] input connected within 2.5 us of strobe
// [R15] data pins driven only while enable high
// [R16] done high after last step until trigger
// [R17] steps advance only on conversion clock edges
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`include "sms_defs.svh"

module sms_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic [2:0] addr_sel,
    input wire logic ale,
    input wire logic conversion_trigger,
    input wire logic conv_clk,
    input wire logic comp_in,
    input wire logic output_enable,
    output logic [7:0] analog_sel,
    output logic mux_ready,
    output logic [7:0] dac_code,
    output logic conv_done,
    output logic [7:0] data_out,
    output logic [7:0] data_oe
);
    localparam logic [9:0] MUX_CYC = 10'(`SMS_MUX_CYC);

    // binary channel number to one-hot switch select
    function automatic logic [7:0] chan_onehot(input logic [2:0] c);
        chan_onehot = 8'h01 << c;
    endfunction

    sms_pkg::sms_state_e state_reg, state_next;
    logic [7:0] sar_reg, sar_next;
    logic [2:0] idx_reg, idx_next;
    logic [7:0] result_reg, result_next;
    logic done_reg, done_next;
    logic ale_q, trig_q, cclk_q;
    logic [2:0] chan_reg;
    logic [9:0] settle_reg;
    logic ready_reg;
    logic [1:0] ctrl_reg;
    logic [1:0] istat_reg, imask_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [7:0] dout_reg, doe_reg;
    logic irq_reg;
    logic [7:0] sel_reg;

    // edge detection on synchronous pin inputs
    wire ale_rise = ale & ~ale_q;
    wire trig_eff = conversion_trigger | ctrl_reg[`SMS_CTRL_SOFT]
                  | (ctrl_reg[`SMS_CTRL_RETRIG] & done_reg);
    wire trig_rise = trig_eff & ~trig_q;
    wire trig_fall = ~trig_eff & trig_q;
    wire conv_edge = conv_clk & ~cclk_q;

    // one approximation step: settle current bit, try next lower
    wire [7:0] bit_mask = chan_onehot(idx_reg);
    wire [7:0] sar_keep = comp_in ? sar_reg : (sar_reg & ~bit_mask);
    wire [7:0] sar_step = sar_keep | (bit_mask >> 1);
    wire last_step = (idx_reg == 3'h0);

    // bus decode
    wire bus_req = avs_read | avs_write;
    wire bus_do = bus_req & ~wait_reg;
    wire wr_do = avs_write & ~wait_reg;
    wire hit_ctrl = (avs_address == `SMS_OFS_CTRL);
    wire hit_stat = (avs_address == `SMS_OFS_STATUS);
    wire hit_res = (avs_address == `SMS_OFS_RESULT);
    wire hit_ist = (avs_address == `SMS_OFS_IRQ_STAT);
    wire hit_imk = (avs_address == `SMS_OFS_IRQ_MASK);

    // status view of the block
    sms_pkg::sms_stat_s stat_view;
    assign stat_view.channel = chan_reg;
    assign stat_view.mux_ready = ready_reg;
    assign stat_view.busy = (state_reg == sms_pkg::SMS_RUN)
                          | (state_reg == sms_pkg::SMS_HOLD);
    assign stat_view.done = done_reg;

    // read data selection, unmapped reads return zero
    wire [31:0] rd_mux =
        hit_ctrl ? {30'h0, ctrl_reg} :
        hit_stat ? {26'h0, stat_view} :
        hit_res ? {24'h0, result_reg} :
        hit_ist ? {30'h0, istat_reg} :
        hit_imk ? {30'h0, imask_reg} : 32'h0;

    // interrupt events and write-one-to-clear, set wins
    wire ready_settle = ~ready_reg & (settle_reg == MUX_CYC);
    wire [1:0] ev = {ready_settle, ~done_reg & done_next};
    wire [1:0] iclr = (wr_do & hit_ist) ? avs_writedata[1:0] : 2'h0;
    wire [1:0] istat_next = (istat_reg & ~iclr) | ev;

    // conversion sequencer
    always_comb begin
        state_next = state_reg;
        sar_next = sar_reg;
        idx_next = idx_reg;
        result_next = result_reg;
        done_next = done_reg;
        if (trig_rise) begin
            state_next = sms_pkg::SMS_ARMED; // see [R5]
            sar_next = 8'h00; // see [R3]
            done_next = 1'b0; // see [R6]
        end else if (trig_fall && state_reg == sms_pkg::SMS_ARMED) begin
            state_next = sms_pkg::SMS_RUN; // see [R4]
            sar_next = `SMS_SAR_TOP;
            idx_next = `SMS_MSB_IDX;
        end else if (conv_edge) begin // see [R17]
            unique case (state_reg)
                sms_pkg::SMS_RUN: begin
                    sar_next = last_step ? sar_keep : sar_step; // see [R8]
                    idx_next = idx_reg - 3'h1;
                    if (last_step) begin
                        result_next = sar_keep; // see [R7] [R9]
                        state_next = sms_pkg::SMS_HOLD;
                    end
                end
                sms_pkg::SMS_HOLD: begin
                    done_next = 1'b1; // see [R16]
                    state_next = sms_pkg::SMS_DONE;
                end
                sms_pkg::SMS_IDLE,
                sms_pkg::SMS_ARMED,
                sms_pkg::SMS_DONE: begin
                end
            endcase
        end
    end

    // sequencer state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= sms_pkg::SMS_IDLE;
            sar_reg <= 8'h00;
            idx_reg <= 3'h0;
            result_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sar_reg <= sar_next;
            idx_reg <= idx_next;
            result_reg <= result_next;
            done_reg <= done_next;
        end
    end

    // previous pin levels and effective trigger for edge detection
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ale_q <= 1'b0;
            trig_q <= 1'b0;
            cclk_q <= 1'b0;
        end else begin
            ale_q <= ale;
            trig_q <= trig_eff; // see [R10]
            cclk_q <= conv_clk;
        end
    end

    // address latch and settling timer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chan_reg <= 3'h0;
            sel_reg <= 8'h01;
            settle_reg <= 10'h0;
            ready_reg <= 1'b0;
        end else if (ale_rise) begin
            chan_reg <= addr_sel; // see [R1]
            sel_reg <= chan_onehot(addr_sel); // see [R2]
            settle_reg <= 10'h0;
            ready_reg <= 1'b0;
        end else begin
            if (!ready_reg) begin
                settle_reg <= settle_reg + 10'h1;
            end
            if (ready_settle) begin
                ready_reg <= 1'b1; // see [R14]
            end
        end
    end

    // bus slave: one wait cycle, then answer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            wait_reg <= ~(bus_req & wait_reg);
            if (bus_req && wait_reg) begin
                rdata_reg <= avs_read ? rd_mux : 32'h0;
            end
        end
    end

    // software registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `SMS_CTRL_RST;
            imask_reg <= `SMS_IRQ_RST;
            istat_reg <= `SMS_IRQ_RST;
            irq_reg <= 1'b0;
        end else begin
            if (wr_do && hit_ctrl) begin
                ctrl_reg <= avs_writedata[1:0];
            end
            if (wr_do && hit_imk) begin
                imask_reg <= avs_writedata[1:0];
            end
            istat_reg <= istat_next;
            irq_reg <= |(istat_next & imask_reg);
        end
    end

    // data pins follow the result register while enabled
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dout_reg <= 8'h00;
            doe_reg <= 8'h00;
        end else begin
            dout_reg <= result_reg; // see [R9]
            doe_reg <= {8{output_enable}}; // see [R15]
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign irq = irq_reg;
    assign analog_sel = sel_reg;
    assign mux_ready = ready_reg;
    assign dac_code = sar_reg;
    assign conv_done = done_reg;
    assign data_out = dout_reg;
    assign data_oe = doe_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // checks on the strobe and multiplexer
    a_ale_latch: assert property ( // see [R1]
        ale_rise |=> chan_reg == $past(addr_sel) && !mux_ready)
        else $error("channel not latched on strobe");
    a_chan_decode: assert property ( // see [R2]
        ale_rise |=> ##1 analog_sel == (8'h01 << $past(addr_sel, 2)))
        else $error("wrong channel selected");
    a_mux_settle: assert property ( // see [R14]
        !mux_ready |-> settle_reg <= MUX_CYC)
        else $error("settling took too long");
    // checks on the conversion sequence
    a_trig_clear: assert property ( // see [R3]
        trig_rise |=> dac_code == 8'h00 && state_reg == sms_pkg::SMS_ARMED)
        else $error("trigger did not clear register");
    a_fall_start: assert property ( // see [R4]
        trig_fall && state_reg == sms_pkg::SMS_ARMED
        |=> state_reg == sms_pkg::SMS_RUN && dac_code == 8'h80)
        else $error("conversion did not start");
    a_restart_run: assert property ( // see [R5]
        state_reg == sms_pkg::SMS_RUN && trig_rise
        |=> state_reg == sms_pkg::SMS_ARMED && idx_reg == $past(idx_reg))
        else $error("running conversion not abandoned");
    a_done_drop: assert property ( // see [R6]
        trig_rise |=> !conv_done)
        else $error("done did not fall");
    a_load_result: assert property ( // see [R7]
        state_reg == sms_pkg::SMS_RUN && conv_edge && last_step && !trig_rise
        |=> result_reg == $past(sar_keep) && !conv_done)
        else $error("result not loaded before done");
    a_done_after: assert property ( // see [R7]
        state_reg == sms_pkg::SMS_HOLD && conv_edge && !trig_rise
        |=> conv_done && $stable(result_reg))
        else $error("done not raised one clock after load");
    a_step_down: assert property ( // see [R8]
        state_reg == sms_pkg::SMS_RUN && conv_edge && !last_step && !trig_rise
        |=> idx_reg == $past(idx_reg) - 3'h1 && state_reg == sms_pkg::SMS_RUN)
        else $error("step order wrong");
    a_done_hold: assert property ( // see [R16]
        state_reg == sms_pkg::SMS_DONE && !trig_rise |=> conv_done)
        else $error("done dropped early");
    a_clk_only: assert property ( // see [R17]
        state_reg == sms_pkg::SMS_RUN && !conv_edge && !trig_rise
        |=> $stable(dac_code) && $stable(idx_reg))
        else $error("step without conversion clock");
    a_self_retrig: assert property ( // see [R10]
        ctrl_reg == 2'h1 && !conversion_trigger && $rose(conv_done)
        |=> state_reg == sms_pkg::SMS_ARMED ##1 state_reg == sms_pkg::SMS_RUN)
        else $error("continuous mode did not restart");
    a_pin_drive: assert property ( // see [R15]
        output_enable |=> data_oe == 8'hff && data_out == $past(result_reg))
        else $error("data pins not driven");
    a_pin_float: assert property ( // see [R15]
        !output_enable |=> data_oe == 8'h00)
        else $error("data pins driven while disabled");
endmodule // sms_top
